// [pfxs_pkg.sv]
package pfxs_pkg;

	// ==================================================================
	// Configuration index values and reset values.
	localparam logic [7:0] PFXS_IDX_PAR_SER = 8'h04;
	localparam logic [7:0] PFXS_IDX_FLOPPY = 8'h05;
	localparam logic [7:0] PFXS_PAR_SER_RST = 8'h00;
	localparam logic [7:0] PFXS_FLOPPY_RST = 8'h00;
	localparam logic [7:0] PFXS_IDX_RST = 8'h00;

	// Bits that read back from the floppy setup register; the rest read zero.
	localparam logic [7:0] PFXS_FLOPPY_RD_MASK = 8'h7C;

	// ==================================================================
	// Field positions in the parallel and serial setup register.
	localparam int PFXS_PS_MODE_LSB = 0;
	localparam int PFXS_PS_ROUTE_LSB = 2;
	localparam int PFXS_PS_CLK1_BIT = 4;
	localparam int PFXS_PS_CLK2_BIT = 5;
	localparam int PFXS_PS_EPP_BIT = 6;
	localparam int PFXS_PS_ALTIR_BIT = 7;

	// Field positions in the floppy setup register.
	localparam int PFXS_FD_DMA_BIT = 2;
	localparam int PFXS_FD_DENS_LSB = 3;
	localparam int PFXS_FD_SWAP_BIT = 5;
	localparam int PFXS_FD_EXT_BIT = 6;

	// ==================================================================
	// Mode and field encodings.
	localparam logic [1:0] PFXS_MODE_SPP = 2'h0;
	localparam logic [1:0] PFXS_MODE_EPP_SPP = 2'h1;
	localparam logic [1:0] PFXS_MODE_ECP = 2'h2;
	localparam logic [1:0] PFXS_MODE_ECP_EPP = 2'h3;
	localparam logic [2:0] PFXS_ECR_SPP = 3'h0;
	localparam logic [2:0] PFXS_ECR_EPP = 3'h4;
	localparam logic [1:0] PFXS_DENS_FORCE_HI = 2'h2;
	localparam logic [1:0] PFXS_DENS_FORCE_LO = 2'h3;

	// ==================================================================
	// Baud path: divide the reference tick by 13 (normal) or 12 (music link), then by 16.
	localparam logic [3:0] PFXS_DIV_NORMAL = 4'hD;
	localparam logic [3:0] PFXS_DIV_MIDI = 4'hC;
	localparam logic [3:0] PFXS_OVERSAMPLE = 4'hF;

	typedef enum logic [1:0] {PFXS_OP_SPP, PFXS_OP_EPP, PFXS_OP_ECP} pfxs_op_t;

	// Floppy side signals from the controller core.
	typedef struct packed {
		logic [1:0] drive_num;
		logic drive_en;
		logic [1:0] motor;
		logic density;
		logic dma_req;
		logic irq;
		logic byte_done;
		logic fifo_en;
	} pfxs_fdc_in_t;

	// Floppy side signals to the pins.
	typedef struct packed {
		logic [1:0] drive_sel;
		logic ext_decode;
		logic [1:0] motor;
		logic density;
		logic floppy_dma_request;
		logic floppy_interrupt;
	} pfxs_fdc_out_t;

	typedef struct packed {
		logic [3:0] cnt;
		logic [3:0] sub;
		logic tick16;
		logic bit_tick;
	} pfxs_baud_t;

endpackage

// [pfxs_setup_regs.sv]
`timescale 1ns/1ps
module pfxs_setup_regs
	import pfxs_pkg::*;
(
	// Clock and reset.
	input wire logic clk,
	input wire logic srst,
	// Configuration port.
	input wire logic cfg_mode,
	input wire logic idx_we,
	input wire logic data_we,
	input wire logic data_re,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	// Bits of neighbouring configuration registers.
	input wire logic [1:0] config_reg_zero_low,
	input wire logic config_reg_one_mode_ext,
	// Parallel port.
	input wire logic [2:0] ecr_mode,
	output pfxs_op_t par_op,
	output logic [1:0] par_mode,
	output logic [1:0] par_floppy_route,
	output logic epp_v17,
	// Serial ports.
	input wire logic baud_ref_tick,
	output logic primary_serial_clock_select,
	output logic secondary_serial_clock_select,
	output pfxs_baud_t baud1,
	output pfxs_baud_t baud2,
	// Infrared.
	input wire logic ir_tx,
	output logic ir_rx,
	input wire logic primary_ir_receive,
	input wire logic alternate_ir_receive,
	output logic primary_ir_transmit,
	output logic alternate_ir_transmit,
	// Floppy.
	input pfxs_fdc_in_t fdc_in,
	output pfxs_fdc_out_t fdc_out
);

	// ==================================================================
	// State.
	typedef struct packed {
		logic [7:0] idx;
		logic [7:0] ps;
		logic [7:0] fd;
		logic [7:0] rdata;
		pfxs_op_t op;
		pfxs_baud_t b1;
		pfxs_baud_t b2;
		logic ir_rx;
		logic ir_tx_pri;
		logic ir_tx_alt;
		pfxs_fdc_out_t fo;
		logic byte_seen;
	} pfxs_state_t;

	pfxs_state_t st_r;
	pfxs_state_t st_nxt;

	// One divider stage for a serial port; sel picks 12 instead of 13.
	function automatic pfxs_baud_t baud_step(input pfxs_baud_t b, input logic sel, input logic ref_tick);
		pfxs_baud_t n;
		logic [3:0] last;
		n = b;
		last = (sel ? PFXS_DIV_MIDI : PFXS_DIV_NORMAL) - 4'h1;
		n.tick16 = 1'b0;
		n.bit_tick = 1'b0;
		if (ref_tick) begin
			if (b.cnt >= last) begin
				n.cnt = 4'h0;
				n.tick16 = 1'b1;
				n.sub = b.sub + 4'h1;
				n.bit_tick = (b.sub == PFXS_OVERSAMPLE);
			end else begin
				n.cnt = b.cnt + 4'h1;
			end
		end
		return n;
	endfunction

	logic ps_hit;
	logic fd_hit;
	logic alt_ok;
	logic [1:0] dnum;
	logic [1:0] dens;

	// ==================================================================
	// Next-state logic.
	always_comb begin
		st_nxt = st_r;
		ps_hit = cfg_mode && (st_r.idx == PFXS_IDX_PAR_SER);
		fd_hit = cfg_mode && (st_r.idx == PFXS_IDX_FLOPPY);

		// Registers are only reachable in configuration mode.
		if (cfg_mode && idx_we) begin
			st_nxt.idx = wdata;
		end
		if (data_we && ps_hit) begin
			st_nxt.ps = wdata;
		end
		if (data_we && fd_hit) begin
			st_nxt.fd = wdata & PFXS_FLOPPY_RD_MASK;
		end
		if (data_re) begin
			if (ps_hit) begin
				st_nxt.rdata = st_r.ps;
			end else if (fd_hit) begin
				st_nxt.rdata = st_r.fd & PFXS_FLOPPY_RD_MASK;
			end else begin
				st_nxt.rdata = 8'h00;
			end
		end

		// Parallel operating mode; the ECR code can override within ECP modes.
		case (st_r.ps[PFXS_PS_MODE_LSB +: 2])
			PFXS_MODE_SPP: st_nxt.op = PFXS_OP_SPP;
			PFXS_MODE_EPP_SPP: st_nxt.op = PFXS_OP_EPP;
			PFXS_MODE_ECP: st_nxt.op = (ecr_mode == PFXS_ECR_SPP) ? PFXS_OP_SPP : PFXS_OP_ECP;
			PFXS_MODE_ECP_EPP: begin
				if (ecr_mode == PFXS_ECR_EPP) begin
					st_nxt.op = PFXS_OP_EPP;
				end else if (ecr_mode == PFXS_ECR_SPP) begin
					st_nxt.op = PFXS_OP_SPP;
				end else begin
					st_nxt.op = PFXS_OP_ECP;
				end
			end
			default: st_nxt.op = PFXS_OP_SPP;
		endcase
		// The extension flag hands the mode choice elsewhere; fall back to plain SPP.
		if (config_reg_one_mode_ext) begin
			st_nxt.op = PFXS_OP_SPP;
		end

		// Baud dividers for both serial ports.
		st_nxt.b1 = baud_step(st_r.b1, st_r.ps[PFXS_PS_CLK1_BIT], baud_ref_tick);
		st_nxt.b2 = baud_step(st_r.b2, st_r.ps[PFXS_PS_CLK2_BIT], baud_ref_tick);

		// Infrared pin routing; alternate pins stay idle unless enabled.
		alt_ok = (config_reg_zero_low == 2'h3);
		if (!st_r.ps[PFXS_PS_ALTIR_BIT]) begin
			st_nxt.ir_rx = primary_ir_receive;
			st_nxt.ir_tx_pri = ir_tx;
			st_nxt.ir_tx_alt = 1'b0;
		end else begin
			st_nxt.ir_rx = alt_ok ? alternate_ir_receive : 1'b0;
			st_nxt.ir_tx_pri = 1'b0;
			st_nxt.ir_tx_alt = alt_ok ? ir_tx : 1'b0;
		end

		// Drive and motor swap.
		dnum = fdc_in.drive_num;
		st_nxt.fo.motor = fdc_in.motor;
		if (st_r.fd[PFXS_FD_SWAP_BIT]) begin
			if (!dnum[1]) begin
				dnum[0] = ~dnum[0];
			end
			st_nxt.fo.motor = {fdc_in.motor[0], fdc_in.motor[1]};
		end
		// Internal decoder drives two one-hot selects; external mode emits the drive number.
		st_nxt.fo.ext_decode = st_r.fd[PFXS_FD_EXT_BIT];
		if (st_r.fd[PFXS_FD_EXT_BIT]) begin
			st_nxt.fo.drive_sel = fdc_in.drive_en ? dnum : 2'h0;
		end else begin
			st_nxt.fo.drive_sel = 2'h0;
			if (fdc_in.drive_en && !dnum[1]) begin
				st_nxt.fo.drive_sel[dnum[0]] = 1'b1;
			end
		end

		// Density output forcing; the reserved code behaves as normal.
		dens = st_r.fd[PFXS_FD_DENS_LSB +: 2];
		case (dens)
			PFXS_DENS_FORCE_HI: st_nxt.fo.density = 1'b1;
			PFXS_DENS_FORCE_LO: st_nxt.fo.density = 1'b0;
			default: st_nxt.fo.density = fdc_in.density;
		endcase

		// Non-burst DMA drops the request for two cycles after each byte and strobes the interrupt.
		st_nxt.byte_seen = 1'b0;
		if (st_r.fd[PFXS_FD_DMA_BIT] && fdc_in.fifo_en) begin
			st_nxt.byte_seen = fdc_in.byte_done;
			st_nxt.fo.floppy_dma_request = fdc_in.dma_req && !fdc_in.byte_done && !st_r.byte_seen;
			st_nxt.fo.floppy_interrupt = fdc_in.irq || fdc_in.byte_done;
		end else begin
			st_nxt.fo.floppy_dma_request = fdc_in.dma_req;
			st_nxt.fo.floppy_interrupt = fdc_in.irq;
		end
	end

	// ==================================================================
	// State register.
	always_ff @(posedge clk) begin
		if (srst) begin
			st_r <= '0;
			st_r.idx <= PFXS_IDX_RST;
			st_r.ps <= PFXS_PAR_SER_RST;
			st_r.fd <= PFXS_FLOPPY_RST;
			st_r.op <= PFXS_OP_SPP;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==================================================================
	// Outputs.
	assign rdata = st_r.rdata;
	assign par_op = st_r.op;
	assign par_mode = st_r.ps[PFXS_PS_MODE_LSB +: 2];
	assign par_floppy_route = st_r.ps[PFXS_PS_ROUTE_LSB +: 2];
	assign epp_v17 = st_r.ps[PFXS_PS_EPP_BIT];
	assign primary_serial_clock_select = st_r.ps[PFXS_PS_CLK1_BIT];
	assign secondary_serial_clock_select = st_r.ps[PFXS_PS_CLK2_BIT];
	assign baud1 = st_r.b1;
	assign baud2 = st_r.b2;
	assign ir_rx = st_r.ir_rx;
	assign primary_ir_transmit = st_r.ir_tx_pri;
	assign alternate_ir_transmit = st_r.ir_tx_alt;
	assign fdc_out = st_r.fo;

	// ==================================================================
	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	AST_PS_WRITE: assert property (cfg_mode && data_we && st_r.idx == PFXS_IDX_PAR_SER |=> st_r.ps == $past(wdata))
		else $error("parallel/serial setup write lost");
	AST_FD_WRITE: assert property (cfg_mode && data_we && st_r.idx == PFXS_IDX_FLOPPY |=> st_r.fd == ($past(wdata) & 8'h7C))
		else $error("floppy setup write wrong");
	AST_NO_CFG: assert property (!cfg_mode |=> st_r.ps == $past(st_r.ps) && st_r.fd == $past(st_r.fd))
		else $error("register changed outside configuration mode");
	AST_FD_LOW_ZERO: assert property (data_re && cfg_mode && st_r.idx == PFXS_IDX_FLOPPY |=> rdata[1:0] == 2'h0)
		else $error("floppy setup low bits not zero");
	AST_FD_TOP_ZERO: assert property (data_re && cfg_mode && st_r.idx == PFXS_IDX_FLOPPY |=> rdata[7] == 1'b0)
		else $error("floppy setup top bit not zero");
	AST_ECR_EPP: assert property (!config_reg_one_mode_ext && par_mode == PFXS_MODE_ECP_EPP
		&& ecr_mode == PFXS_ECR_EPP |=> par_op == PFXS_OP_EPP || $past(par_mode) != $past(par_mode, 2))
		else $error("combined mode did not enter EPP");
	AST_ECR_SPP: assert property (!config_reg_one_mode_ext && par_mode[1] && ecr_mode == PFXS_ECR_SPP
		##1 par_mode == $past(par_mode) |-> par_op == PFXS_OP_SPP)
		else $error("ECP mode did not enter SPP");
	AST_BAUD13: assert property (baud_ref_tick && !primary_serial_clock_select && baud1.cnt == 4'hC |=> baud1.tick16)
		else $error("primary divide by 13 wrong");
	AST_BAUD12: assert property (baud_ref_tick && secondary_serial_clock_select && baud2.cnt == 4'hB |=> baud2.tick16)
		else $error("secondary divide by 12 wrong");
	AST_ALT_IDLE: assert property (st_r.ps[7] && config_reg_zero_low != 2'h3 ##1 st_r.ps[7] |-> !alternate_ir_transmit)
		else $error("alternate infrared pin driven while disabled");
	AST_SWAP: assert property (st_r.fd[5] && fdc_in.motor == 2'h1 ##1 st_r.fd[5] |-> fdc_out.motor == 2'h2)
		else $error("motor swap missing");
	AST_DENS: assert property (st_r.fd[4:3] == PFXS_DENS_FORCE_HI ##1 st_r.fd[4:3] == PFXS_DENS_FORCE_HI |-> fdc_out.density)
		else $error("density not forced high");
	AST_NONBURST: assert property (st_r.fd[2] && fdc_in.fifo_en && fdc_in.byte_done
		|=> !fdc_out.floppy_dma_request && fdc_out.floppy_interrupt)
		else $error("non-burst strobe missing");

	// Plain mode decode, bit timing, pin routing, drive selects, density forcing low and burst pass-through;
	// the bit tick is checked within its own cycle, the rest one cycle after their inputs.
	AST_EXT_SPP: assert property (config_reg_one_mode_ext |=> par_op == PFXS_OP_SPP)
		else $error("mode extension flag did not force SPP");
	AST_MODE_SPP: assert property (!config_reg_one_mode_ext && par_mode == PFXS_MODE_SPP
		|=> par_op == PFXS_OP_SPP)
		else $error("SPP mode not selected");
	AST_MODE_EPP: assert property (!config_reg_one_mode_ext && par_mode == PFXS_MODE_EPP_SPP
		|=> par_op == PFXS_OP_EPP)
		else $error("EPP mode not selected");
	AST_BAUD_BIT: assert property (baud1.bit_tick == (baud1.tick16 && baud1.sub == 4'h0))
		else $error("primary bit tick not on the sixteenth divider pulse");
	AST_IR_PRI: assert property (!st_r.ps[PFXS_PS_ALTIR_BIT]
		|=> primary_ir_transmit == $past(ir_tx) && !alternate_ir_transmit && ir_rx == $past(primary_ir_receive))
		else $error("primary infrared pins not in use");
	AST_ALT_ON: assert property (st_r.ps[PFXS_PS_ALTIR_BIT] && config_reg_zero_low == 2'h3
		|=> alternate_ir_transmit == $past(ir_tx) && ir_rx == $past(alternate_ir_receive) && !primary_ir_transmit)
		else $error("alternate infrared pins not in use");
	AST_SWAP_SEL: assert property (st_r.fd[6:5] == 2'h1 && fdc_in.drive_en && fdc_in.drive_num == 2'h0
		|=> fdc_out.drive_sel == 2'h2)
		else $error("drive select swap missing");
	AST_INT_SEL: assert property (st_r.fd[6:5] == 2'h0 && fdc_in.drive_en && fdc_in.drive_num == 2'h0
		|=> fdc_out.drive_sel == 2'h1 && !fdc_out.ext_decode)
		else $error("internal decoder select wrong");
	AST_EXT_SEL: assert property (st_r.fd[6] && fdc_in.drive_en && fdc_in.drive_num[1]
		|=> fdc_out.drive_sel == $past(fdc_in.drive_num) && fdc_out.ext_decode)
		else $error("external decoder select wrong");
	AST_DENS_LO: assert property (st_r.fd[4:3] == PFXS_DENS_FORCE_LO |=> !fdc_out.density)
		else $error("density not forced low");
	AST_BURST: assert property (!st_r.fd[2] |=> fdc_out.floppy_dma_request == $past(fdc_in.dma_req))
		else $error("burst request not passed through");

	COV_ECP_EPP: cover property (par_mode == PFXS_MODE_ECP_EPP && par_op == PFXS_OP_EPP);
	COV_NONBURST: cover property (fdc_out.floppy_interrupt && !fdc_out.floppy_dma_request);
	COV_MIDI_BIT: cover property (primary_serial_clock_select && baud1.bit_tick);
	COV_ALT_IR: cover property (st_r.ps[7] && alternate_ir_transmit);
	COV_EXT4: cover property (fdc_out.ext_decode && fdc_out.drive_sel == 2'h3);

endmodule

// [pfxs_setup_regs_tb.sv]
`timescale 1ns/1ps
module pfxs_setup_regs_tb
	import pfxs_pkg::*;
;
	// ==================================================================
	// Stimulus and observed signals.
	logic clk, srst, cfg_mode, idx_we, data_we, data_re, baud_ref_tick;
	logic config_reg_one_mode_ext, ir_tx, ir_rx, primary_ir_receive, alternate_ir_receive;
	logic primary_ir_transmit, alternate_ir_transmit, primary_serial_clock_select, secondary_serial_clock_select;
	logic epp_v17;
	logic [7:0] wdata, rdata, v;
	logic [1:0] config_reg_zero_low, par_mode, par_floppy_route;
	logic [2:0] ecr_mode;
	pfxs_op_t par_op;
	pfxs_baud_t baud1, baud2;
	pfxs_fdc_in_t fdc_in;
	pfxs_fdc_out_t fdc_out;
	int fail_count, checks, n;
	int cyc = 0;

	pfxs_setup_regs u_pfxs_setup_regs (.clk(clk), .srst(srst), .cfg_mode(cfg_mode), .idx_we(idx_we),
		.data_we(data_we), .data_re(data_re), .wdata(wdata), .rdata(rdata),
		.config_reg_zero_low(config_reg_zero_low), .config_reg_one_mode_ext(config_reg_one_mode_ext),
		.ecr_mode(ecr_mode), .par_op(par_op), .par_mode(par_mode), .par_floppy_route(par_floppy_route),
		.epp_v17(epp_v17), .baud_ref_tick(baud_ref_tick), .primary_serial_clock_select(primary_serial_clock_select),
		.secondary_serial_clock_select(secondary_serial_clock_select), .baud1(baud1), .baud2(baud2),
		.ir_tx(ir_tx), .ir_rx(ir_rx), .primary_ir_receive(primary_ir_receive),
		.alternate_ir_receive(alternate_ir_receive), .primary_ir_transmit(primary_ir_transmit),
		.alternate_ir_transmit(alternate_ir_transmit), .fdc_in(fdc_in), .fdc_out(fdc_out));

	// ==================================================================
	// Clock and hang guard; the whole run needs well under 3000 cycles.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			wrap_up();
		end
	end

	// ==================================================================
	// Shared tasks.
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Index write, then a data write in the next cycle; strobes drop after the taking edge.
	task automatic wr(input logic c, input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		cfg_mode <= c;
		idx_we <= 1'b1;
		wdata <= idx;
		@(posedge clk);
		idx_we <= 1'b0;
		data_we <= 1'b1;
		wdata <= d;
		@(posedge clk);
		data_we <= 1'b0;
	endtask

	task automatic rd(input logic c, input logic [7:0] idx, output logic [7:0] d);
		@(posedge clk);
		cfg_mode <= c;
		idx_we <= 1'b1;
		wdata <= idx;
		@(posedge clk);
		idx_we <= 1'b0;
		data_re <= 1'b1;
		@(posedge clk);
		data_re <= 1'b0;
		#1 d = rdata;
	endtask

	// Registered outputs are looked at just after the edge that takes their inputs.
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	function automatic logic sg(input int s);
		return (s == 0) ? baud1.tick16 : (s == 1) ? baud2.tick16 : baud1.bit_tick;
	endfunction

	// Cycles between two pulses, bounded so a dead counter cannot hang the run.
	task automatic per(input int s, output int k);
		k = 0;
		while (!sg(s) && k < 400) begin
			step(1);
			k++;
		end
		k = 0;
		do begin
			step(1);
			k++;
		end while (!sg(s) && k < 400);
	endtask

	task automatic wrap_up();
		if (fail_count == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ==================================================================
	// Main sequence.
	initial begin
		fail_count = 0;
		checks = 0;
		srst = 1'b1;
		{cfg_mode, idx_we, data_we, data_re, baud_ref_tick, config_reg_one_mode_ext, ir_tx} = '0;
		{primary_ir_receive, alternate_ir_receive} = '0;
		wdata = 8'h00;
		config_reg_zero_low = 2'h0;
		ecr_mode = 3'h0;
		fdc_in = '0;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		rd(1'b1, PFXS_IDX_PAR_SER, v);
		chk("par_ser reset", v, 8'h00);
		rd(1'b1, PFXS_IDX_FLOPPY, v);
		chk("floppy reset", v, 8'h00);
		wr(1'b1, PFXS_IDX_FLOPPY, 8'hFF);
		rd(1'b1, PFXS_IDX_FLOPPY, v);
		chk("floppy fixed bits", v, 8'h7C);
		wr(1'b0, PFXS_IDX_FLOPPY, 8'h00);
		rd(1'b1, PFXS_IDX_FLOPPY, v);
		chk("write outside cfg", v, 8'h7C);
		rd(1'b0, PFXS_IDX_FLOPPY, v);
		chk("read outside cfg", v, 8'h00);
		rd(1'b1, 8'h06, v);
		chk("unmapped index", v, 8'h00);
		wr(1'b1, PFXS_IDX_PAR_SER, 8'h5B);
		rd(1'b1, PFXS_IDX_PAR_SER, v);
		chk("par_ser readback", v, 8'h5B);
		chk("route field", par_floppy_route, 2'h2);
		chk("epp version", epp_v17, 1'b1);
		chk("clock selects", {primary_serial_clock_select, secondary_serial_clock_select}, 2'h2);
		// Mode and control code pairs against the effective operation; the last pass is EPP with SPP.
		for (int i = 0; i < 8; i++) begin
			logic [1:0] m;
			logic [2:0] e;
			pfxs_op_t x;
			m = (i < 2) ? 2'h0 : (i < 5) ? 2'h2 : (i < 7) ? 2'h3 : 2'h1;
			e = (i == 2 || i == 6) ? 3'h0 : (i == 4 || i == 5) ? 3'h4 : 3'h1;
			x = (i < 2 || e == 3'h0) ? PFXS_OP_SPP : (i == 5 || i == 7) ? PFXS_OP_EPP : PFXS_OP_ECP;
			config_reg_one_mode_ext <= (i == 1);
			ecr_mode <= e;
			wr(1'b1, PFXS_IDX_PAR_SER, {6'h00, (i == 1) ? 2'h3 : m});
			step(2);
			chk("par_mode", par_mode, (i == 1) ? 2'h3 : m);
			chk("par_op", par_op, x);
		end
		// Baud path: one clock select high, the other low.
		wr(1'b1, PFXS_IDX_PAR_SER, 8'h10);
		baud_ref_tick <= 1'b1;
		per(0, n);
		chk("divide by 12", n[7:0], 8'h0C);
		per(1, n);
		chk("divide by 13", n[7:0], 8'h0D);
		per(2, n);
		chk("bit tick period", n[7:0], 8'hC0);
		wr(1'b1, PFXS_IDX_PAR_SER, 8'h20);
		step(2);
		per(0, n);
		chk("divide by 13 p", n[7:0], 8'h0D);
		per(1, n);
		chk("divide by 12 s", n[7:0], 8'h0C);
		// Infrared routing: primary, alternate enabled, alternate blocked; the unused receive pin differs.
		ir_tx <= 1'b1;
		primary_ir_receive <= 1'b1;
		alternate_ir_receive <= 1'b0;
		config_reg_zero_low <= 2'h3;
		wr(1'b1, PFXS_IDX_PAR_SER, 8'h00);
		step(2);
		chk("ir primary", {ir_rx, primary_ir_transmit, alternate_ir_transmit}, 3'h6);
		primary_ir_receive <= 1'b0;
		alternate_ir_receive <= 1'b1;
		wr(1'b1, PFXS_IDX_PAR_SER, 8'h80);
		step(2);
		chk("ir alternate", {ir_rx, primary_ir_transmit, alternate_ir_transmit}, 3'h5);
		config_reg_zero_low <= 2'h1;
		step(2);
		chk("ir blocked", {ir_rx, primary_ir_transmit, alternate_ir_transmit}, 3'h0);
		// Floppy: swap, internal and external decoding, density forcing.
		fdc_in.drive_en <= 1'b1;
		fdc_in.motor <= 2'h1;
		fdc_in.density <= 1'b0;
		wr(1'b1, PFXS_IDX_FLOPPY, 8'h10);
		step(2);
		chk("no swap", {fdc_out.drive_sel, fdc_out.ext_decode, fdc_out.motor, fdc_out.density}, 8'h13);
		wr(1'b1, PFXS_IDX_FLOPPY, 8'h38);
		step(2);
		chk("swap", {fdc_out.drive_sel, fdc_out.ext_decode, fdc_out.motor, fdc_out.density}, 8'h24);
		fdc_in.drive_num <= 2'h2;
		fdc_in.density <= 1'b1;
		wr(1'b1, PFXS_IDX_FLOPPY, 8'h60);
		step(2);
		chk("external", {fdc_out.drive_sel, fdc_out.ext_decode, fdc_out.density}, 8'h0B);
		// Non-burst strobing, then burst pass-through.
		fdc_in.fifo_en <= 1'b1;
		fdc_in.dma_req <= 1'b1;
		wr(1'b1, PFXS_IDX_FLOPPY, 8'h04);
		step(2);
		@(posedge clk);
		fdc_in.byte_done <= 1'b1;
		@(posedge clk);
		fdc_in.byte_done <= 1'b0;
		#1 chk("nonburst strobe", {fdc_out.floppy_dma_request, fdc_out.floppy_interrupt}, 2'h1);
		step(1);
		chk("nonburst hold", fdc_out.floppy_dma_request, 1'b0);
		wr(1'b1, PFXS_IDX_FLOPPY, 8'h00);
		@(posedge clk);
		fdc_in.byte_done <= 1'b1;
		@(posedge clk);
		fdc_in.byte_done <= 1'b0;
		#1 chk("burst", {fdc_out.floppy_dma_request, fdc_out.floppy_interrupt}, 2'h2);
		wrap_up();
	end
endmodule
